// ===== rtl/bbx_pkg.sv
// package with opcodes, flag positions, states and timing counts for the branch and bit executor
package bbx_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam int OFS_W = 7;
	localparam int IO_AW = 5;
	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	// cycle counts
	localparam int CYC_BRANCH_NOT_TAKEN = 1;
	localparam int CYC_BRANCH_TAKEN = 2;
	localparam int CYC_IO_BIT = 2;
	localparam int CYC_SINGLE = 1;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_BR_NEG = 5'h01,
		OP_BR_NONNEG = 5'h02,
		OP_BR_SGE = 5'h03,
		OP_BR_SLT = 5'h04,
		OP_BR_HSET = 5'h05,
		OP_BR_HCLR = 5'h06,
		OP_BR_VCLR = 5'h07,
		OP_BR_IEN = 5'h08,
		OP_BR_IDIS = 5'h09,
		OP_IO_SET = 5'h0a,
		OP_IO_CLR = 5'h0b,
		OP_SHL = 5'h0c,
		OP_SHR = 5'h0d,
		OP_ROL = 5'h0e,
		OP_ROR = 5'h0f,
		OP_ASR = 5'h10,
		OP_SWAP = 5'h11,
		OP_FLAG_SET = 5'h12,
		OP_FLAG_CLR = 5'h13,
		OP_TO_T = 5'h14,
		OP_FROM_T = 5'h15,
		OP_SET_C = 5'h16,
		OP_CLR_C = 5'h17,
		OP_SET_N = 5'h18
	} bbx_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BRANCH = 2'b01,
		ST_IO = 2'b11
	} bbx_state_t;
endpackage

// ===== rtl/bbx_alu_if.sv
// interface carrying shift unit operands and results between the executor and its shifter
`timescale 1ns/1ns
interface bbx_alu_if;
	import bbx_pkg::*;
	bbx_op_t op;
	logic [DATA_W-1:0] operand;
	logic carry_in;
	logic [DATA_W-1:0] result;
	logic [3:0] flags_zcnv;
	modport exec(output op, output operand, output carry_in, input result, input flags_zcnv);
	modport unit(input op, input operand, input carry_in, output result, output flags_zcnv);
endinterface

// ===== rtl/bbx_shifter.sv
// combinational shift, rotate and swap unit with zero, carry, negative and overflow results
`timescale 1ns/1ns
module bbx_shifter (
	bbx_alu_if.unit alu
);
	import bbx_pkg::*;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] r;
	logic c;
	logic n;
	always_comb begin
		a = alu.operand;
		r = a;
		c = alu.carry_in;
		case (alu.op)
			OP_SHL: begin
				r = {a[DATA_W-2:0], 1'b0};
				c = a[DATA_W-1];
			end
			OP_SHR: begin
				r = {1'b0, a[DATA_W-1:1]};
				c = a[0];
			end
			OP_ROL: begin
				r = {a[DATA_W-2:0], alu.carry_in};
				c = a[DATA_W-1];
			end
			OP_ROR: begin
				r = {alu.carry_in, a[DATA_W-1:1]};
				c = a[0];
			end
			OP_ASR: begin
				r = {a[DATA_W-1], a[DATA_W-1:1]};
				c = a[0];
			end
			OP_SWAP: begin
				r = {a[3:0], a[7:4]};
			end
			default: begin
				r = a;
			end
		endcase
		n = r[DATA_W-1];
		alu.result = r;
		// order is z, c, n, v; overflow is negative xor carry after the shift
		alu.flags_zcnv = {(r == '0), c, n, n ^ c};
	end
endmodule // bbx_shifter

// ===== rtl/bbx_exec.sv
// executor for conditional branches, i/o bit writes, shifts, rotates and flag/bit moves
//
// How it works
// - branch on negative set or clear
// - branch when negative xor overflow clear
// - branch when negative xor overflow set
// - branch on half carry set or clear
// - branch when overflow flag clear
// - branch when interrupt enable set
// - branch when interrupt enable clear
// - set one i/o bit, two cycles
// - clear one i/o bit, two cycles
// - shift left, zero in, flags updated
// - shift right, zero in, flags updated
// - rotate left through carry
// - rotate right through carry
// - arithmetic shift right keeps top bit
// - swap nibbles, flags untouched
// - copy register bit into transfer flag
// - write transfer flag into register bit
`timescale 1ns/1ns
module bbx_exec (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic OP_VALID,
	input wire bbx_pkg::bbx_op_t OP_CODE,
	input wire logic [bbx_pkg::OFS_W-1:0] BRANCH_OFFSET,
	input wire logic [2:0] BIT_SEL,
	input wire logic [bbx_pkg::IO_AW-1:0] IO_ADDR,
	input wire logic [bbx_pkg::DATA_W-1:0] REG_DATA,
	input wire logic [bbx_pkg::DATA_W-1:0] IO_RDATA,
	output logic READY,
	output logic DONE,
	output logic [bbx_pkg::PC_W-1:0] PROGRAM_COUNTER,
	output logic [7:0] STATUS_FLAGS,
	output logic REG_WE,
	output logic [bbx_pkg::DATA_W-1:0] REG_WDATA,
	output logic IO_RE,
	output logic IO_WE,
	output logic [bbx_pkg::IO_AW-1:0] IO_WADDR,
	output logic [bbx_pkg::DATA_W-1:0] IO_WDATA
);
	import bbx_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	bbx_state_t state;
	bbx_state_t next_state;
	bbx_alu_if alu ();
	logic take;
	logic accept;
	logic [PC_W-1:0] pc_inc;
	logic [PC_W-1:0] pc_target;
	logic [PC_W-1:0] branch_pc;
	logic io_set;
	logic [2:0] io_bit;
	logic [IO_AW-1:0] io_addr;
	logic is_shift;

	bbx_shifter u_shifter (
		.alu(alu)
	);

	assign alu.op = OP_CODE;
	assign alu.operand = REG_DATA;
	assign alu.carry_in = STATUS_FLAGS[FLAG_C];
	assign accept = OP_VALID && READY;
	assign pc_inc = PROGRAM_COUNTER + PC_W'(1);
	// offset is sign extended, target is pc + k + 1
	assign pc_target = pc_inc + {{(PC_W-OFS_W){BRANCH_OFFSET[OFS_W-1]}}, BRANCH_OFFSET};
	assign is_shift = (OP_CODE == OP_SHL) || (OP_CODE == OP_SHR) || (OP_CODE == OP_ROL) ||
		(OP_CODE == OP_ROR) || (OP_CODE == OP_ASR);

	////////////////////////////////////////////////////////////////////////////////
	// branch condition evaluation
	always_comb begin
		case (OP_CODE)
			OP_BR_NEG: take = STATUS_FLAGS[FLAG_N];
			OP_BR_NONNEG: take = !STATUS_FLAGS[FLAG_N];
			OP_BR_SGE: take = !(STATUS_FLAGS[FLAG_N] ^ STATUS_FLAGS[FLAG_V]);
			OP_BR_SLT: take = STATUS_FLAGS[FLAG_N] ^ STATUS_FLAGS[FLAG_V];
			OP_BR_HSET: take = STATUS_FLAGS[FLAG_H];
			OP_BR_HCLR: take = !STATUS_FLAGS[FLAG_H];
			OP_BR_VCLR: take = !STATUS_FLAGS[FLAG_V];
			OP_BR_IEN: take = STATUS_FLAGS[FLAG_I];
			OP_BR_IDIS: take = !STATUS_FLAGS[FLAG_I];
			default: take = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencing: taken branch and i/o bit writes need a second cycle
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept && take) begin
					next_state = ST_BRANCH;
				end else if (accept && (OP_CODE == OP_IO_SET || OP_CODE == OP_IO_CLR)) begin
					next_state = ST_IO;
				end
			end
			ST_BRANCH: next_state = ST_IDLE;
			ST_IO: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			READY <= 1'b1;
			DONE <= 1'b0;
		end else begin
			READY <= (next_state == ST_IDLE);
			DONE <= (accept && next_state == ST_IDLE) || (state != ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// program counter
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			PROGRAM_COUNTER <= PC_RESET;
			branch_pc <= PC_RESET;
		end else if (accept && take) begin
			branch_pc <= pc_target;
		end else if (state == ST_BRANCH) begin
			PROGRAM_COUNTER <= branch_pc;
		end else if (accept && next_state == ST_IDLE) begin
			// i/o bit ops step the pc only once, when their write cycle ends
			PROGRAM_COUNTER <= pc_inc;
		end else if (state == ST_IO) begin
			PROGRAM_COUNTER <= pc_inc;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status flags; branches, i/o writes, swap and bit load leave them alone
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			STATUS_FLAGS <= FLAGS_RESET;
		end else if (accept) begin
			if (is_shift) begin
				STATUS_FLAGS[FLAG_Z] <= alu.flags_zcnv[3];
				STATUS_FLAGS[FLAG_C] <= alu.flags_zcnv[2];
				STATUS_FLAGS[FLAG_N] <= alu.flags_zcnv[1];
				STATUS_FLAGS[FLAG_V] <= alu.flags_zcnv[0];
			end
			case (OP_CODE)
				OP_FLAG_SET: STATUS_FLAGS[BIT_SEL] <= 1'b1;
				OP_FLAG_CLR: STATUS_FLAGS[BIT_SEL] <= 1'b0;
				OP_SET_C: STATUS_FLAGS[FLAG_C] <= 1'b1;
				OP_CLR_C: STATUS_FLAGS[FLAG_C] <= 1'b0;
				OP_SET_N: STATUS_FLAGS[FLAG_N] <= 1'b1;
				OP_TO_T: STATUS_FLAGS[FLAG_T] <= REG_DATA[BIT_SEL];
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register write-back
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			REG_WE <= 1'b0;
			REG_WDATA <= '0;
		end else begin
			REG_WE <= 1'b0;
			if (accept && (is_shift || OP_CODE == OP_SWAP)) begin
				REG_WE <= 1'b1;
				REG_WDATA <= alu.result;
			end else if (accept && OP_CODE == OP_FROM_T) begin
				REG_WE <= 1'b1;
				REG_WDATA <= REG_DATA;
				REG_WDATA[BIT_SEL] <= STATUS_FLAGS[FLAG_T];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// i/o bit read-modify-write: read in cycle 1, write in cycle 2
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			io_set <= 1'b0;
			io_bit <= 3'h0;
			io_addr <= '0;
			IO_RE <= 1'b0;
			IO_WE <= 1'b0;
			IO_WADDR <= '0;
			IO_WDATA <= '0;
		end else begin
			IO_RE <= 1'b0;
			IO_WE <= 1'b0;
			if (accept && (OP_CODE == OP_IO_SET || OP_CODE == OP_IO_CLR)) begin
				io_set <= (OP_CODE == OP_IO_SET);
				io_bit <= BIT_SEL;
				io_addr <= IO_ADDR;
				IO_RE <= 1'b1;
				IO_WADDR <= IO_ADDR;
			end else if (state == ST_IO) begin
				IO_WE <= 1'b1;
				IO_WADDR <= io_addr;
				IO_WDATA <= IO_RDATA;
				IO_WDATA[io_bit] <= io_set;
			end
		end
	end
endmodule // bbx_exec

// ===== verif/bbx_io_model.sv
// i/o register space answering the executor's reads and writes
`timescale 1ns/1ns
module bbx_io_model (
	input wire logic REF_CLK,
	input wire logic IO_RE,
	input wire logic IO_WE,
	input wire logic [4:0] IO_WADDR,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA
);
	logic [7:0] mem [32];
	initial foreach (mem[i]) mem[i] = 8'(i * 37);
	// outside a read the bus shows the inverse so stale data cannot pass
	assign IO_RDATA = IO_RE ? mem[IO_WADDR] : ~mem[IO_WADDR];
	always @(posedge REF_CLK) if (IO_WE) mem[IO_WADDR] <= IO_WDATA;
endmodule // bbx_io_model

// ===== verif/bbx_exec_monitor.sv
// concurrent checks on the executor ports
`timescale 1ns/1ns
module bbx_exec_monitor (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic OP_VALID,
	input wire bbx_pkg::bbx_op_t OP_CODE,
	input wire logic [6:0] BRANCH_OFFSET,
	input wire logic [2:0] BIT_SEL,
	input wire logic [4:0] IO_ADDR,
	input wire logic [7:0] REG_DATA,
	input wire logic [7:0] IO_RDATA,
	input wire logic READY,
	input wire logic DONE,
	input wire logic [15:0] PROGRAM_COUNTER,
	input wire logic [7:0] STATUS_FLAGS,
	input wire logic REG_WE,
	input wire logic [7:0] REG_WDATA,
	input wire logic IO_RE,
	input wire logic IO_WE,
	input wire logic [4:0] IO_WADDR,
	input wire logic [7:0] IO_WDATA
);
	import bbx_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	wire acc = OP_VALID && READY;
	wire [15:0] sk = {{9{BRANCH_OFFSET[6]}}, BRANCH_OFFSET};
	a_taken_branch: assert property (
		acc && OP_CODE == OP_BR_NEG && STATUS_FLAGS[FLAG_N] |=> !READY && !DONE ##1
		DONE && PROGRAM_COUNTER == $past(PROGRAM_COUNTER, 2) + $past(sk, 2) + 16'h0001) else $error("taken branch");
	a_untaken_one: assert property (
		acc && OP_CODE == OP_BR_NONNEG && STATUS_FLAGS[FLAG_N] |=>
		DONE && PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 16'h0001) else $error("untaken branch");
	a_signed_lt: assert property (
		acc && OP_CODE == OP_BR_SLT |=> READY == !$past(STATUS_FLAGS[FLAG_N] ^ STATUS_FLAGS[FLAG_V]))
		else $error("signed less branch");
	a_branch_flags: assert property (
		acc && OP_CODE inside {[OP_BR_NEG:OP_BR_IDIS]} |=> $stable(STATUS_FLAGS)) else $error("branch moved flags");
	a_io_set: assert property (
		acc && OP_CODE == OP_IO_SET |=> IO_RE && !READY ##1 IO_WE && DONE && IO_WADDR == $past(IO_ADDR, 2) &&
		IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(BIT_SEL, 2)))) else $error("io bit set");
	a_io_clear: assert property (
		acc && OP_CODE == OP_IO_CLR |=> IO_RE ##1 IO_WE && DONE &&
		IO_WDATA == ($past(IO_RDATA) & ~(8'h01 << $past(BIT_SEL, 2)))) else $error("io bit clear");
	a_shift_left: assert property (
		acc && OP_CODE == OP_SHL |=> REG_WE && REG_WDATA == {$past(REG_DATA[6:0]), 1'b0} &&
		STATUS_FLAGS[FLAG_C] == $past(REG_DATA[7])) else $error("shift left");
	a_swap_keeps: assert property (
		acc && OP_CODE == OP_SWAP |=> REG_WDATA == {$past(REG_DATA[3:0]), $past(REG_DATA[7:4])} &&
		$stable(STATUS_FLAGS)) else $error("nibble swap");
	a_bit_to_t: assert property (
		acc && OP_CODE == OP_TO_T |=> STATUS_FLAGS[FLAG_T] == $past(REG_DATA[BIT_SEL])) else $error("bit to t");
	c_taken: cover property (acc && OP_CODE == OP_BR_NEG && STATUS_FLAGS[FLAG_N]);
	c_io_write: cover property (IO_WE && DONE);
	c_rotate: cover property (acc && OP_CODE == OP_ROR);
endmodule // bbx_exec_monitor
bind bbx_exec bbx_exec_monitor i_bbx_exec_monitor (.*);

// ===== verif/bbx_exec_tb.sv
// self-checking bench for the branch and bit executor
`timescale 1ns/1ns
module bbx_exec_tb;
	import bbx_pkg::*;
	logic REF_CLK = 1'b0, NRST = 1'b0, OP_VALID = 1'b0;
	bbx_op_t OP_CODE = OP_NOP;
	logic [6:0] BRANCH_OFFSET = 7'h00;
	logic [2:0] BIT_SEL = 3'h0;
	logic [4:0] IO_ADDR = 5'h00, IO_WADDR;
	logic [7:0] REG_DATA = 8'h00, IO_RDATA, STATUS_FLAGS, REG_WDATA, IO_WDATA, fl = 8'h00;
	logic READY, DONE, REG_WE, IO_RE, IO_WE;
	logic [15:0] PROGRAM_COUNTER, pc = 16'h0000;
	logic [32:0] notes[$], n;
	int mismatches = 0, compares = 0;
	bbx_exec i_bbx_exec (.*);
	bbx_io_model i_bbx_io_model (.*);
	always #2 REF_CLK = ~REF_CLK;
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic taken(bbx_op_t op, logic [7:0] f);
		case (op)
			OP_BR_NEG: return f[FLAG_N];
			OP_BR_NONNEG: return !f[FLAG_N];
			OP_BR_SGE: return !(f[FLAG_N] ^ f[FLAG_V]);
			OP_BR_SLT: return f[FLAG_N] ^ f[FLAG_V];
			OP_BR_HSET: return f[FLAG_H];
			OP_BR_HCLR: return !f[FLAG_H];
			OP_BR_VCLR: return !f[FLAG_V];
			OP_BR_IEN: return f[FLAG_I];
			OP_BR_IDIS: return !f[FLAG_I];
			default: return 1'b0;
		endcase
	endfunction
	task automatic run(bbx_op_t op);
		logic [7:0] d = 8'($urandom);
		logic [7:0] r = d;
		logic [6:0] k = 7'($urandom);
		logic [2:0] b = 3'($urandom);
		logic c = fl[FLAG_C];
		OP_VALID <= 1'b1;
		OP_CODE <= op;
		BRANCH_OFFSET <= k;
		BIT_SEL <= b;
		IO_ADDR <= 5'($urandom);
		REG_DATA <= d;
		do @(posedge REF_CLK); while (READY !== 1'b1);
		pc = pc + 16'h0001;
		if (taken(op, fl)) pc = pc + {{9{k[6]}}, k};
		case (op)
			OP_SHL: {c, r} = {d, 1'b0};
			OP_SHR: {r, c} = {1'b0, d};
			OP_ROL: {c, r} = {d, fl[FLAG_C]};
			OP_ROR: {r, c} = {fl[FLAG_C], d};
			OP_ASR: {r, c} = {d[7], d};
			OP_SWAP: r = {d[3:0], d[7:4]};
			OP_FLAG_SET: fl[b] = 1'b1;
			OP_FLAG_CLR: fl[b] = 1'b0;
			OP_TO_T: fl[FLAG_T] = d[b];
			OP_FROM_T: r[b] = fl[FLAG_T];
			OP_SET_C: fl[FLAG_C] = 1'b1;
			OP_CLR_C: fl[FLAG_C] = 1'b0;
			OP_SET_N: fl[FLAG_N] = 1'b1;
			default: ;
		endcase
		if (op inside {[OP_SHL:OP_ASR]}) fl[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
		notes.push_back({op inside {[OP_SHL:OP_SWAP], OP_FROM_T}, r, fl, pc});
	endtask
	always @(negedge REF_CLK) if (NRST && DONE === 1'b1) begin
		n = notes.size() ? notes.pop_front() : 33'bx;
		check("pc", PROGRAM_COUNTER, n[15:0]);
		check("flags", {8'h00, STATUS_FLAGS}, {8'h00, n[23:16]});
		check("reg write", 16'(REG_WE), 16'(n[32]));
		if (n[32]) check("reg data", {8'h00, REG_WDATA}, {8'h00, n[31:24]});
	end
	initial begin
		void'($urandom(32'h29730a27));
		repeat (2) @(posedge REF_CLK);
		NRST <= 1'b1;
		@(posedge REF_CLK);
		for (int i = 0; i < 400; i++) run(i < 24 ? bbx_op_t'(i + 1) : bbx_op_t'($urandom_range(24, 1)));
		OP_VALID <= 1'b0;
		repeat (4) @(posedge REF_CLK);
		results();
	end
	initial begin
		#20000;
		mismatches++;
		results();
	end
endmodule // bbx_exec_tb
